// ===== design/cmld_pkg.sv
package cmld_pkg;
	// opcode fields and values
	localparam logic [7:0]  OP_OR_LIT    = 8'h09; // or literal into working
	localparam logic [7:0]  OP_BANK_LIT  = 8'h01; // load bank literal
	localparam logic [7:0]  OP_WORK_LIT  = 8'h0e; // load working literal
	localparam logic [5:0]  OP_OR_FILE   = 6'h04; // 0001 00 d a
	localparam logic [5:0]  OP_COPY_FILE = 6'h14; // 0101 00 d a
	localparam logic [9:0]  OP_PTR_LIT   = 10'h3b8; // 1110 1110 00
	localparam logic [7:0]  OP_PTR_TAIL  = 8'hf0; // 1111 0000
	localparam logic [3:0]  OP_MOVE_SRC  = 4'hc; // file to file first word
	localparam logic [3:0]  OP_MOVE_TAIL = 4'hf; // second word prefix
	// field positions
	localparam int          D_BIT        = 9; // destination bit
	localparam int          A_BIT        = 8; // access bit
	// protected destinations of the file to file move
	localparam logic [11:0] ADDR_PC_LOW  = 12'hff9; // program counter low
	localparam logic [11:0] ADDR_TOS_LO  = 12'hffd; // stack top low
	localparam logic [11:0] ADDR_TOS_HI  = 12'hffe; // stack top high
	localparam logic [11:0] ADDR_TOS_UP  = 12'hfff; // stack top upper
	localparam logic [11:0] ADDR_WORK    = 12'hfe8; // working register alias
	localparam logic [7:0]  ACCESS_SPLIT = 8'h80; // access bank split point
	localparam logic [3:0]  ACCESS_HIGH  = 4'hf; // access bank upper page
	localparam logic [7:0]  RESET_BYTE   = 8'h00; // reset value of registers
	localparam int          NUM_PTRS     = 3; // file select pointers

	// one bus write to the data file
	typedef struct packed {
		logic        en;   // write strobe
		logic [11:0] addr; // byte address
		logic [7:0]  data; // byte
	} cmld_wr_type;

	// status flags
	typedef struct packed {
		logic neg;  // negative
		logic zero; // zero
	} cmld_flags_type;
endpackage

// ===== design/cmld_core.sv
// Behaviour
// - literal OR updates working register
// - file OR writes working or file
// - file copy to working or file
// - file copy sets only negative, zero
// - access bit picks access or banked
// - omitted destination bit means file
// - pointer load decodes as two words
// - pointer high first, low second cycle
// - pointer select only zero to two
// - move takes source, destination addresses
// - move reads Q2, writes second Q4
// - move never writes counter or stack
// - move passes working register unchanged
// - bank literal written Q4, no flags
// - working literal, one cycle, no flags
`timescale 1ns/10ps
`default_nettype none
module cmld_core
	import cmld_pkg::*;
(
	input  wire logic                    CLK,       // cpu clock, one quarter per rising edge
	input  wire logic                    RSTN,      // asynchronous reset, active low
	input  wire logic [15:0]             INSTR,     // program word, held for the cycle
	input  wire logic [7:0]              RD_DATA,   // data file byte read at RD_ADDR
	output logic      [11:0]             RD_ADDR,   // data file read address
	output cmld_pkg::cmld_wr_type        WR,        // data file write, one quarter
	output logic      [7:0]              WORK,      // working register
	output logic      [7:0]              BANK,      // bank select register
	output cmld_pkg::cmld_flags_type     FLAGS,     // negative and zero
	output logic      [3*12-1:0]         PTRS,      // three file select pointers
	output logic                         ILLEGAL,   // bad pointer select or move target
	output logic      [3:0]              QPHASE     // one-hot quarter in force
);
	import cmld_pkg::*;

	// quarter phases, one-hot
	typedef enum logic [3:0] {
		Q1 = 4'b0001,
		Q2 = 4'b0010,
		Q3 = 4'b0100,
		Q4 = 4'b1000
	} cmld_q_type;

	// what the second word of a two word instruction finishes
	typedef enum logic [2:0] {
		P_NONE = 3'b001, // single word
		P_PTR  = 3'b010, // pointer load tail
		P_MOVE = 3'b100  // file to file tail
	} cmld_pend_type;

	// bank mapped address of an 8-bit file operand
	function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [7:0] bank_select_register);
		if (!w[A_BIT]) // access bank ignores the bank select register
			file_addr = (w[7:0] < ACCESS_SPLIT) ? {4'h0, w[7:0]} : {ACCESS_HIGH, w[7:0]};
		else // 256 byte bank from the bank select register
			file_addr = {bank_select_register[3:0], w[7:0]};
	endfunction

	// destinations that the move may not write
	function automatic logic protected_dest(input logic [11:0] a);
		protected_dest = (a == ADDR_PC_LOW) || (a == ADDR_TOS_LO) ||
			(a == ADDR_TOS_HI) || (a == ADDR_TOS_UP);
	endfunction

	cmld_q_type     q_q, q_d;           // quarter
	cmld_pend_type  pend_q, pend_d;     // pending second word
	logic [7:0]     work_q, work_d;     // working register
	logic [7:0]     bank_q, bank_d;     // bank select register
	cmld_flags_type flg_q, flg_d;       // status flags
	logic [11:0]    ptr_q [NUM_PTRS];   // pointers
	logic [11:0]    ptr_d [NUM_PTRS];   // pointer next values
	logic [1:0]     psel_q, psel_d;     // selected pointer
	logic [7:0]     hold_q, hold_d;     // operand byte read in Q2
	logic [11:0]    raddr_q, raddr_d;   // read address
	cmld_wr_type    wr_q, wr_d;         // write strobe
	logic           ill_q, ill_d;       // illegal sticky flag
	logic [7:0]     res;                // alu result
	logic [7:0]     op_lit;             // literal operand

	// next state of the whole execute path
	always_comb
	begin
		q_d     = q_q;
		pend_d  = pend_q;
		work_d  = work_q;
		bank_d  = bank_q;
		flg_d   = flg_q;
		ptr_d   = ptr_q;
		psel_d  = psel_q;
		hold_d  = hold_q;
		raddr_d = raddr_q;
		wr_d    = '0;
		ill_d   = ill_q;
		op_lit  = INSTR[7:0];
		res     = RESET_BYTE;
		unique case (q_q)
			Q1:
			begin
				// decode: present operand address
				q_d = Q2;
				if (pend_q == P_NONE)
				begin
					if (INSTR[15:12] == OP_MOVE_SRC) // source address
						raddr_d = INSTR[11:0];
					else
						raddr_d = file_addr(INSTR, bank_q);
				end
			end
			Q2:
			begin
				// read operand
				q_d    = Q3;
				// the second word of a two word instruction reads nothing, so
				// the move keeps the byte taken in its first cycle
				if (pend_q == P_NONE)
					hold_d = (raddr_q == ADDR_WORK) ? work_q : RD_DATA;
			end
			Q3:
				q_d = Q4;
			Q4:
			begin
				// write results
				q_d    = Q1;
				pend_d = P_NONE;
				unique case (pend_q)
					P_PTR:
					begin
						// low byte in the second cycle
						if (INSTR[15:8] == OP_PTR_TAIL)
							ptr_d[psel_q] = {ptr_q[psel_q][11:8], op_lit};
					end
					P_MOVE:
					begin
						// destination written in second cycle Q4
						if (INSTR[15:12] == OP_MOVE_TAIL)
						begin
							if (protected_dest(INSTR[11:0]))
								ill_d = 1'b1;
							else if (INSTR[11:0] == ADDR_WORK)
								work_d = hold_q;
							else
							begin
								wr_d.en   = 1'b1;
								wr_d.addr = INSTR[11:0];
								wr_d.data = hold_q; // byte unchanged, no flags
							end
						end
					end
					default:
					begin
						if (INSTR[15:8] == OP_OR_LIT)
						begin
							res    = work_q | op_lit;
							work_d = res;
							flg_d  = '{neg: res[7], zero: (res == 8'h00)};
						end
						else if (INSTR[15:8] == OP_BANK_LIT)
							bank_d = op_lit;
						else if (INSTR[15:8] == OP_WORK_LIT)
							work_d = op_lit;
						else if (INSTR[15:10] == OP_OR_FILE || INSTR[15:10] == OP_COPY_FILE)
						begin
							// or / copy; d set writes back to f
							res = (INSTR[15:10] == OP_OR_FILE) ? (work_q | hold_q) : hold_q;
							flg_d = '{neg: res[7], zero: (res == 8'h00)};
							if (!INSTR[D_BIT] || raddr_q == ADDR_WORK)
								work_d = res;
							else
							begin
								wr_d.en   = 1'b1;
								wr_d.addr = raddr_q;
								wr_d.data = res;
							end
						end
						else if (INSTR[15:6] == OP_PTR_LIT)
						begin
							// first word: high nibble
							if (INSTR[5:4] < 2'(NUM_PTRS))
							begin
								psel_d = INSTR[5:4];
								ptr_d[INSTR[5:4]] = {INSTR[3:0], ptr_q[INSTR[5:4]][7:0]};
								pend_d = P_PTR;
							end
							else
								ill_d = 1'b1;
						end
						else if (INSTR[15:12] == OP_MOVE_SRC)
							pend_d = P_MOVE; // two words, two cycles
					end
				endcase
			end
			default:
				q_d = Q1;
		endcase
	end

	// register the execute path
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			q_q     <= Q1;
			pend_q  <= P_NONE;
			work_q  <= RESET_BYTE;
			bank_q  <= RESET_BYTE;
			flg_q   <= '0;
			for (int i = 0; i < NUM_PTRS; i++)
				ptr_q[i] <= 12'h000;
			psel_q  <= 2'h0;
			hold_q  <= RESET_BYTE;
			raddr_q <= 12'h000;
			wr_q    <= '0;
			ill_q   <= 1'b0;
		end
		else
		begin
			q_q     <= q_d;
			pend_q  <= pend_d;
			work_q  <= work_d;
			bank_q  <= bank_d;
			flg_q   <= flg_d;
			ptr_q   <= ptr_d;
			psel_q  <= psel_d;
			hold_q  <= hold_d;
			raddr_q <= raddr_d;
			wr_q    <= wr_d;
			ill_q   <= ill_d;
		end
	end

	// outputs straight from flip-flops
	assign RD_ADDR = raddr_q;
	assign WR      = wr_q;
	assign WORK    = work_q;
	assign BANK    = bank_q;
	assign FLAGS   = flg_q;
	assign PTRS    = {ptr_q[2], ptr_q[1], ptr_q[0]};
	assign ILLEGAL = ill_q;
	assign QPHASE  = q_q;

	// literal or lands in working register after Q4
	a_or_literal_result: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q4 && pend_q == P_NONE && INSTR[15:8] == OP_OR_LIT)
		|=> work_q == ($past(work_q) | $past(INSTR[7:0])))
		else $error("literal or result wrong");

	a_working_literal: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q4 && pend_q == P_NONE && INSTR[15:8] == OP_WORK_LIT)
		|=> work_q == $past(INSTR[7:0]) && flg_q == $past(flg_q))
		else $error("working literal load wrong");

	a_bank_literal: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q4 && pend_q == P_NONE && INSTR[15:8] == OP_BANK_LIT)
		|=> bank_q == $past(INSTR[7:0]) && flg_q == $past(flg_q))
		else $error("bank literal load wrong");

	a_flag_zero: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q4 && pend_q == P_NONE && INSTR[15:8] == OP_OR_LIT)
		|=> flg_q.zero == (work_q == 8'h00) && flg_q.neg == work_q[7])
		else $error("flags do not follow result");

	a_write_only_q4: assert property (@(posedge CLK) disable iff (!RSTN)
		wr_q.en |-> q_q == Q1)
		else $error("data write outside Q4");

	a_no_protected_write: assert property (@(posedge CLK) disable iff (!RSTN)
		wr_q.en && $past(pend_q) == P_MOVE |-> !protected_dest(wr_q.addr))
		else $error("move wrote protected register");

	a_pointer_select: assert property (@(posedge CLK) disable iff (!RSTN)
		pend_q == P_PTR |-> psel_q < 2'(NUM_PTRS))
		else $error("pointer select out of range");

	a_copy_to_working: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q4 && pend_q == P_NONE && INSTR[15:10] == OP_COPY_FILE && !INSTR[D_BIT])
		|=> work_q == $past(hold_q) && !wr_q.en)
		else $error("copy to working wrong");

	a_quarter_cycle: assert property (@(posedge CLK) disable iff (!RSTN)
		q_q == Q1 |=> q_q == Q2 ##1 q_q == Q3 ##1 q_q == Q4 ##1 q_q == Q1)
		else $error("quarter sequence broken");

	// source byte must survive the second cycle of the move
	a_move_source_held: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q2 && pend_q == P_MOVE) |=> hold_q == $past(hold_q))
		else $error("move source byte overwritten");

	// legal move target gets exactly the held byte in the second cycle
	a_move_tail_write: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q4 && pend_q == P_MOVE && INSTR[15:12] == OP_MOVE_TAIL &&
		!protected_dest(INSTR[11:0]) && INSTR[11:0] != ADDR_WORK)
		|=> wr_q.en && wr_q.addr == $past(INSTR[11:0]) && wr_q.data == $past(hold_q))
		else $error("move destination write wrong");

	// move leaves the status flags alone
	a_move_no_flags: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q4 && pend_q == P_MOVE) |=> flg_q == $past(flg_q))
		else $error("move changed flags");

	// pointer select three is refused and touches no pointer
	a_pointer_refused: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q4 && pend_q == P_NONE && INSTR[15:6] == OP_PTR_LIT && INSTR[5:4] == 2'h3)
		|=> ill_q && pend_q == P_NONE && PTRS == $past(PTRS))
		else $error("bad pointer select not refused");

	// access bank address ignores the bank select register
	a_access_bank: assert property (@(posedge CLK) disable iff (!RSTN)
		(q_q == Q1 && pend_q == P_NONE && INSTR[15:12] != OP_MOVE_SRC && !INSTR[A_BIT])
		|=> raddr_q == {($past(INSTR[7]) ? ACCESS_HIGH : 4'h0), $past(INSTR[7:0])})
		else $error("access bank address wrong");
endmodule // cmld_core
`default_nettype wire

// ===== testbench/cmld_data_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmld_data_model
	import cmld_pkg::*;
(
	input  wire logic                  CLK,             // cpu clock
	input  wire logic [11:0]           RD_ADDR,         // read address
	input  wire cmld_pkg::cmld_wr_type WR,              // write from core
	output logic      [7:0]            RD_DATA          // byte at read address
);
	logic [7:0] mem [4096]; // whole data space
	// start clean so no unknown byte is read
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	// read follows the address at once, any quarter
	assign RD_DATA = mem[RD_ADDR];
	// one byte per strobe, only where the core aims it
	always @(posedge CLK)
	begin
		if (WR.en === 1'b1)
			mem[WR.addr] <= WR.data;
	end
endmodule // cmld_data_model
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import cmld_pkg::*;
	logic           clk = 1'b0;      // cpu clock
	logic           rstn = 1'b0;     // reset, active low
	logic [15:0]    instr = 16'h0;   // program word
	logic [7:0]     rd_data;         // byte from data file
	logic [11:0]    rd_addr;         // read address
	cmld_wr_type    wr;              // write from core
	logic [7:0]     work;            // working register
	logic [7:0]     bank;            // bank select register
	cmld_flags_type flags;           // status flags
	logic [35:0]    ptrs;            // three pointers
	logic           illegal;         // refusal flag
	logic [3:0]     qphase;          // quarter in force
	int             mismatches = 0;  // failed checks
	int             total_checks = 0; // all checks
	int             cycles = 0;      // cycles run
	logic [11:0]    bad [4] = '{12'hff9, 12'hffd, 12'hffe, 12'hfff}; // guarded targets
	// free running clock
	always #5 clk = ~clk;
	cmld_core dut_u (.CLK(clk), .RSTN(rstn), .INSTR(instr), .RD_DATA(rd_data),
		.RD_ADDR(rd_addr), .WR(wr), .WORK(work), .BANK(bank), .FLAGS(flags),
		.PTRS(ptrs), .ILLEGAL(illegal), .QPHASE(qphase));
	cmld_data_model mem_u (.CLK(clk), .RD_ADDR(rd_addr),
		.WR(wr), .RD_DATA(rd_data));
	// cut a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	// compare one result
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one word through its four quarters, ending on a falling edge
	task automatic run(input logic [15:0] w);
		instr = w;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
	// hold reset five cycles, release on a falling edge
	task automatic rst();
		@(negedge clk);
		rstn = 1'b0;
		repeat (5) @(negedge clk);
		chk("qphase", 4'h1, qphase);
		rstn = 1'b1;
	endtask
	// counts and verdict
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial
	begin
		rst();
		run(16'h0e9a);
		chk("work", 8'h9a, work);
		chk("flags", 2'b00, flags);
		run(16'h0935);
		chk("work", 8'hbf, work);
		chk("flags", 2'b10, flags);
		run(16'h0105);
		chk("bank", 8'h05, bank);
		chk("flags", 2'b10, flags);
		mem_u.mem[12'h510] = 8'h13;
		run(16'h0e91);
		run(16'h1110);
		chk("work", 8'h93, work);
		chk("f510", 8'h13, mem_u.mem[12'h510]);
		run(16'h1210);
		run(16'h0000); // idle cycle lets the write land
		chk("f010", 8'h93, mem_u.mem[12'h010]);
		run(16'h5085);
		chk("work", 8'h00, work);
		chk("flags", 2'b01, flags);
		run(16'h5310);
		chk("wr", {1'b1, 12'h510, 8'h13}, wr);
		chk("f510", 8'h13, mem_u.mem[12'h510]);
		chk("work", 8'h00, work);
		chk("flags", 2'b00, flags);
		for (int i = 0; i < 3; i++)
		begin
			run({10'h3b8, 2'(i), 4'(i + 1)});
			chk("ptr_hi", 4'(i + 1), ptrs[i*12+8 +: 4]);
			run(16'hf05a);
			chk("ptr", {4'(i + 1), 8'h5a}, ptrs[i*12 +: 12]);
		end
		run(16'h0980);
		mem_u.mem[12'h123] = 8'h33;
		run(16'hc123);
		chk("wr_en", 1'b0, wr.en);
		mem_u.mem[12'h123] = 8'h44;
		run(16'hf456);
		chk("wr_en", 1'b1, wr.en);
		run(16'h0000); // idle cycle lets the write land
		chk("f456", 8'h33, mem_u.mem[12'h456]);
		chk("flags", 2'b10, flags);
		run(16'hcfe8);
		run(16'hf457);
		run(16'h0000); // idle cycle lets the write land
		chk("f457", 8'h80, mem_u.mem[12'h457]);
		run(16'hc123);
		run(16'hffe8);
		chk("work", 8'h44, work);
		foreach (bad[j])
		begin
			rst();
			chk("illegal", 1'b0, illegal);
			mem_u.mem[bad[j]] = 8'h5c;
			run(16'hc123);
			run({4'hf, bad[j]});
			chk("wr_en", 1'b0, wr.en);
			chk("illegal", 1'b1, illegal);
			run(16'h0000); // idle cycle lets any write land
			chk("target", 8'h5c, mem_u.mem[bad[j]]);
		end
		rst();
		run({10'h3b8, 2'd3, 4'h7});
		run(16'hf011);
		chk("illegal", 1'b1, illegal);
		chk("ptrs", 36'h0, ptrs);
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
